/* logic/ssc_top.sv */
`timescale 1ns/1ps
`include "ssc_defines.svh"

module ssc_top #(
  parameter int CYC_PER_MS = `SSC_CYC_PER_MS
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst, // synchronous, active high
  input wire logic scl_pin, // raw serial clock pin level
  input wire logic data_or_chip_select_pad, // raw serial data pin level
  input wire logic [1:0] reg_addr, // register index
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // registered read data
  input wire logic addr_load, // address bytes complete
  input wire logic [15:0] addr_bytes, // received bytes, low byte last
  input wire logic [31:0] page_reg, // page register contents
  output logic [31:0] csr_addr, // assembled register address
  output logic csr_addr_valid, // pulse with csr_addr
  output ssc_pkg::ssc_cfg_t cfg, // mode, address size, drive
  output ssc_pkg::ssc_drive_t pad_drive, // drive seen by the pads
  output ssc_pkg::ssc_status_t status_flags // sticky timeout flags
);
  logic [7:0] smbus_timeout_control;
  logic scl_meta, scl_sync, sda_meta, sda_sync;
  logic clk_exp, dat_exp;

  // pins pass two flops; only the second is read, the first may be metastable
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end else begin
      scl_meta <= scl_pin;
      scl_sync <= scl_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= data_or_chip_select_pad;
      sda_sync <= sda_meta;
    end
  end

  // field decode
  wire [4:0] timeout_length_ms = smbus_timeout_control[`SSC_CTL_LEN_MSB:`SSC_CTL_LEN_LSB];
  wire data_timeout_enable = smbus_timeout_control[`SSC_CTL_DTO_EN_BIT];
  wire clock_timeout_reserved_bit = smbus_timeout_control[`SSC_CTL_RSV_BIT];
  wire in_smbus = (cfg.mode == ssc_pkg::SSC_MODE_SMB);
  wire len_nonzero = (timeout_length_ms != 5'h0);
  wire scl_low = !scl_sync;
  wire sda_low = !sda_sync;
  wire clk_run = in_smbus && len_nonzero;
  wire dat_run = in_smbus && len_nonzero && data_timeout_enable;
  wire sel_ctl = (reg_addr == `SSC_IDX_SMBUS_TIMEOUT_CONTROL);
  wire sel_glb = (reg_addr == `SSC_IDX_GLOBAL);
  wire sel_sts = (reg_addr == `SSC_IDX_STATUS);
  wire i2c_like = (cfg.mode == ssc_pkg::SSC_MODE_I2C) || in_smbus;

  // both timeouts share the one length field
  ssc_timeout_counter #(.CYC_PER_MS(CYC_PER_MS), .LEN_W(5)) u_clk_to (
    .clk(clk),
    .rst(rst),
    .run(clk_run),
    .line_low(scl_low),
    .length_ms(timeout_length_ms),
    .expired(clk_exp)
  );

  ssc_timeout_counter #(.CYC_PER_MS(CYC_PER_MS), .LEN_W(5)) u_dat_to (
    .clk(clk),
    .rst(rst),
    .run(dat_run),
    .line_low(sda_low),
    .length_ms(timeout_length_ms),
    .expired(dat_exp)
  );

  // control and configuration registers; control bit 7 and global bits 7:5 store nothing, reserved control bit 5 is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      smbus_timeout_control <= `SSC_CTL_RESET;
      cfg <= ssc_pkg::ssc_cfg_t'(5'(`SSC_GLB_RESET));
    end else if (reg_wr && sel_ctl) begin
      smbus_timeout_control <= {1'b0, reg_wdata[6:0]};
    end else if (reg_wr && sel_glb) begin
      cfg <= ssc_pkg::ssc_cfg_t'(reg_wdata[4:0]);
    end
  end

  // a timeout in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      status_flags <= ssc_pkg::ssc_status_t'(`SSC_STS_RESET);
    end else begin
      status_flags.clock_timeout_flag <= clk_exp || (status_flags.clock_timeout_flag &&
        !(reg_wr && sel_sts && reg_wdata[`SSC_STS_CTO_BIT]));
      status_flags.data_timeout_flag <= dat_exp || (status_flags.data_timeout_flag &&
        !(reg_wr && sel_sts && reg_wdata[`SSC_STS_DTO_BIT]));
    end
  end

  // drive setting only reaches the pads in open-drain modes; timing unaffected
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_drive <= ssc_pkg::SSC_DRV_STD;
    end else begin
      pad_drive <= i2c_like ? cfg.drive : ssc_pkg::SSC_DRV_STD;
    end
  end

  // address assembly: page bits fill whatever the host did not send
  wire [31:0] next_csr_addr = cfg.addr_two_bytes ? {page_reg[31:16], addr_bytes} :
                                                   {page_reg[31:8], addr_bytes[7:0]};
  always_ff @(posedge clk) begin
    if (rst) begin
      csr_addr <= 32'h0;
      csr_addr_valid <= 1'b0;
    end else begin
      csr_addr_valid <= addr_load;
      if (addr_load) begin
        csr_addr <= next_csr_addr;
      end
    end
  end

  // read mux; unmapped index reads zero
  wire [7:0] next_rdata = sel_ctl ? {1'b0, data_timeout_enable, clock_timeout_reserved_bit, timeout_length_ms} :
                          sel_glb ? {3'h0, cfg} :
                          sel_sts ? {6'h0, status_flags} : 8'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  property p_len_reset;
    @(posedge clk) rst |=> (timeout_length_ms == `SSC_LEN_RESET) && data_timeout_enable;
  endproperty
  a_len_reset: assert property (p_len_reset) else $error("timeout control reset value wrong");

  property p_no_clk_to_zero;
    @(posedge clk) disable iff (rst) (!len_nonzero && !$past(len_nonzero)) |-> !clk_exp;
  endproperty
  a_no_clk_to_zero: assert property (p_no_clk_to_zero) else $error("clock timeout with zero length");

  property p_dat_gate;
    @(posedge clk) disable iff (rst) !$past(dat_run) |-> !dat_exp;
  endproperty
  a_dat_gate: assert property (p_dat_gate) else $error("data timeout while disabled");

  property p_dat_flag;
    @(posedge clk) disable iff (rst) dat_exp |=> status_flags.data_timeout_flag;
  endproperty
  a_dat_flag: assert property (p_dat_flag) else $error("data timeout flag not set");

  property p_clk_flag;
    @(posedge clk) disable iff (rst) clk_exp |=> status_flags.clock_timeout_flag;
  endproperty
  a_clk_flag: assert property (p_clk_flag) else $error("clock timeout flag not set");

  property p_w1c;
    @(posedge clk) disable iff (rst)
      (reg_wr && sel_sts && reg_wdata[0] && !clk_exp) |=> !status_flags.clock_timeout_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_w0_keeps;
    @(posedge clk) disable iff (rst)
      (status_flags.data_timeout_flag && !(reg_wr && sel_sts && reg_wdata[1])) |=> status_flags.data_timeout_flag;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag dropped without write one");

  property p_drive;
    @(posedge clk) disable iff (rst) !i2c_like |=> (pad_drive == ssc_pkg::SSC_DRV_STD);
  endproperty
  a_drive: assert property (p_drive) else $error("pad drive active outside i2c or smbus");

  // plain nets so that $past sees whole signals
  wire [23:0] page_upper = page_reg[31:8];
  wire [7:0] addr_low_byte = addr_bytes[7:0];
  property p_addr;
    @(posedge clk) disable iff (rst) (addr_load && !cfg.addr_two_bytes) |=>
      csr_addr_valid && (csr_addr == {$past(page_upper), $past(addr_low_byte)});
  endproperty
  a_addr: assert property (p_addr) else $error("one-byte address assembled wrong");

  property p_mode_reset;
    @(posedge clk) rst |=> (cfg.mode == ssc_pkg::SSC_MODE_I2C);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode did not reset to i2c");

  property p_smbus_only;
    @(posedge clk) disable iff (rst) !$past(in_smbus) |-> !clk_exp && !dat_exp;
  endproperty
  a_smbus_only: assert property (p_smbus_only) else $error("timeout outside smbus mode");

  c_clk_to: cover property (@(posedge clk) disable iff (rst) clk_exp);
  c_dat_to: cover property (@(posedge clk) disable iff (rst) dat_exp);
  c_clear: cover property (@(posedge clk) disable iff (rst)
    status_flags.clock_timeout_flag ##1 !status_flags.clock_timeout_flag);
  c_two_byte: cover property (@(posedge clk) disable iff (rst) addr_load && cfg.addr_two_bytes);
endmodule

/* logic/ssc_defines.svh */
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// register indexes on the local configuration port
`define SSC_IDX_SMBUS_TIMEOUT_CONTROL 2'h0
`define SSC_IDX_GLOBAL 2'h1
`define SSC_IDX_STATUS 2'h2

// timeout control field layout
`define SSC_CTL_DTO_EN_BIT 6
`define SSC_CTL_RSV_BIT 5
`define SSC_CTL_LEN_MSB 4
`define SSC_CTL_LEN_LSB 0
`define SSC_CTL_RESET 8'h79
`define SSC_LEN_RESET 5'h19

// global configuration field layout
`define SSC_GLB_DRV_MSB 4
`define SSC_GLB_DRV_LSB 3
`define SSC_GLB_ASIZE_BIT 2
`define SSC_GLB_MODE_MSB 1
`define SSC_GLB_MODE_LSB 0
`define SSC_GLB_RESET 8'h01

// status field layout
`define SSC_STS_DTO_BIT 1
`define SSC_STS_CTO_BIT 0
`define SSC_STS_RESET 2'h0

// timeout unit and clock period, both in ns
`define SSC_MS_NS 1000000
`define SSC_CLK_NS 40
`define SSC_CYC_PER_MS (`SSC_MS_NS / `SSC_CLK_NS)

`endif

/* logic/ssc_pkg.sv */
package ssc_pkg;

  // port mode field encoding
  typedef enum logic [1:0] {
    SSC_MODE_OFF = 2'h0,
    SSC_MODE_I2C = 2'h1,
    SSC_MODE_SPI = 2'h2,
    SSC_MODE_SMB = 2'h3
  } ssc_mode_t;

  // pad drive field encoding; 2'h2 is reserved
  typedef enum logic [1:0] {
    SSC_DRV_STD = 2'h0,
    SSC_DRV_FAST = 2'h1,
    SSC_DRV_RSV = 2'h2,
    SSC_DRV_FASTPLUS = 2'h3
  } ssc_drive_t;

  // configuration handed to the protocol engines
  typedef struct packed {
    ssc_drive_t drive;
    logic addr_two_bytes;
    ssc_mode_t mode;
  } ssc_cfg_t;

  // sticky timeout flags
  typedef struct packed {
    logic data_timeout_flag;
    logic clock_timeout_flag;
  } ssc_status_t;

endpackage

/* logic/ssc_timeout_counter.sv */
`timescale 1ns/1ps
// counts how long a line has stayed low, in milliseconds
module ssc_timeout_counter #(
  parameter int CYC_PER_MS = 25000,
  parameter int LEN_W = 5
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic run, // checking allowed
  input wire logic line_low, // synchronised line is low
  input wire logic [LEN_W-1:0] length_ms, // timeout length
  output logic expired // one-cycle pulse at timeout
);
  localparam int PW = $clog2(CYC_PER_MS);

  logic [PW-1:0] pre;
  logic [LEN_W-1:0] ms;
  logic done;

  // any gap in the condition restarts the whole count
  wire active = run && line_low && (length_ms != '0);
  wire tick = (pre == PW'(CYC_PER_MS - 1));
  wire hit = tick && (ms == length_ms - 1'b1) && !done;

  // done holds off repeat pulses until the line is released
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      pre <= '0;
      ms <= '0;
      done <= 1'b0;
      expired <= 1'b0;
    end else begin
      pre <= tick ? '0 : pre + 1'b1;
      if (tick && !done) begin
        ms <= ms + 1'b1;
      end
      if (hit) begin
        done <= 1'b1;
      end
      expired <= hit;
    end
  end
endmodule

/* bench/ssc_bus_master.sv */
`timescale 1ns/1ps
// far-side bus master: owns the link clock and can stretch either line low
module ssc_bus_master (
  input wire logic frame, // link clock runs while high
  input wire logic hold_scl, // stretch clock low
  input wire logic hold_sda, // pull data low
  output logic scl, // serial clock pin
  output logic sda // serial data pin
);
  logic lclk = 1'b1;
  logic dbit = 1'b1;
  // master-made clock, phase unrelated to the system clock
  initial begin
    #7;
    forever #160 lclk = ~lclk;
  end
  // data changes once per link period, so it can sit low for a full period
  always @(negedge lclk) begin
    dbit <= ~dbit;
  end
  // released lines float high on the pull-up; clock stands still outside frames
  assign scl = hold_scl ? 1'b0 : (frame ? lclk : 1'b1);
  assign sda = hold_sda ? 1'b0 : (frame ? dbit : 1'b1);
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  localparam int CPM = 4;
  logic clk, rst, reg_wr, addr_load, frame, hold_scl, hold_sda, csr_addr_valid, scl_pin, sda_pin;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] addr_bytes;
  logic [31:0] page_reg, csr_addr;
  ssc_pkg::ssc_cfg_t cfg;
  ssc_pkg::ssc_drive_t pad_drive;
  ssc_pkg::ssc_status_t status_flags;
  int mismatches, tests_run;

  ssc_top #(.CYC_PER_MS(CPM)) dut (.clk(clk), .rst(rst), .scl_pin(scl_pin), .data_or_chip_select_pad(sda_pin),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .addr_load(addr_load),
    .addr_bytes(addr_bytes), .page_reg(page_reg), .csr_addr(csr_addr), .csr_addr_valid(csr_addr_valid),
    .cfg(cfg), .pad_drive(pad_drive), .status_flags(status_flags));
  ssc_bus_master bus (.frame(frame), .hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl_pin), .sda(sda_pin));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data lags the index by one cycle
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 `CHK(reg_rdata, e)
  endtask

  // hold lines low up to n cycles; a flag must land at 2 sync + 3 ms + 1, give or take one
  task automatic low_run(input logic s, input logic d, input int n, input logic [1:0] e);
    int cyc;
    @(posedge clk);
    hold_scl <= s;
    hold_sda <= d;
    cyc = 0;
    while (status_flags === 2'h0 && cyc < n) begin
      @(posedge clk);
      #1 cyc++;
    end
    `CHK(status_flags, e)
    if (e !== 2'h0) `CHK(cyc >= 2 + 3 * CPM && cyc <= 4 + 3 * CPM, 1'b1)
    if (e !== 2'h0 && cyc >= n) finish_test();
    @(posedge clk);
    hold_scl <= 1'b0;
    hold_sda <= 1'b0;
  endtask

  task automatic t_reset();
    rd(2'h0, 8'h79);
    rd(2'h1, 8'h01);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    `CHK(pad_drive, 2'h0)
  endtask

  // every mode with every drive value; reserved bits other than control bit 5 must read back zero
  task automatic t_config();
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h7f);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 4; d++) begin
        wr(2'h1, {3'h7, 2'(d), 1'b1, 2'(m)});
        @(posedge clk);
        #1 `CHK(cfg, {2'(d), 1'b1, 2'(m)})
        `CHK(pad_drive, (m == 1 || m == 3) ? 2'(d) : 2'h0)
      end
    end
    rd(2'h1, 8'h1f);
  endtask

  task automatic load(input logic [15:0] b, input logic [31:0] e);
    @(posedge clk);
    addr_load <= 1'b1;
    addr_bytes <= b;
    @(posedge clk);
    addr_load <= 1'b0;
    #1 `CHK({csr_addr_valid, csr_addr}, {1'b1, e})
    @(posedge clk);
    #1 `CHK(csr_addr_valid, 1'b0)
  endtask

  task automatic t_addr();
    @(posedge clk);
    page_reg <= 32'ha5c3_7e10;
    wr(2'h1, 8'h01);
    load(16'h5a96, 32'ha5c3_7e96);
    wr(2'h1, 8'h05);
    load(16'h5a96, 32'ha5c3_5a96);
  endtask

  task automatic t_timeouts();
    wr(2'h1, 8'h03);
    wr(2'h0, 8'h43);
    // normal traffic never holds a line long enough to trip
    frame <= 1'b1;
    repeat (160) @(posedge clk);
    frame <= 1'b0;
    #1 `CHK(status_flags, 2'h0)
    low_run(1'b1, 1'b0, 40, 2'h1);
    wr(2'h2, 8'h00);
    rd(2'h2, 8'h01);
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h00);
    low_run(1'b0, 1'b1, 40, 2'h2);
    wr(2'h2, 8'h02);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'h03);
    low_run(1'b0, 1'b1, 20, 2'h0);
    wr(2'h0, 8'h00);
    low_run(1'b1, 1'b1, 20, 2'h0);
    wr(2'h0, 8'h43);
    wr(2'h1, 8'h01);
    low_run(1'b1, 1'b1, 20, 2'h0);
  endtask

  initial begin
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    addr_load = 1'b0;
    addr_bytes = 16'h0000;
    page_reg = 32'h0000_0000;
    frame = 1'b0;
    hold_scl = 1'b0;
    hold_sda = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_addr();
    t_timeouts();
    finish_test();
  end
endmodule
